// ### core/gpio_cfg.svh
// Constants for the three bytewise I/O ports.
// Assumes an 8-bit data-space address and 8-bit data.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ==================================================
// Register addresses in data space
`define GP_PA_LEVEL_ADDR   8'hc0
`define GP_PB_LEVEL_ADDR   8'hc1
`define GP_PC_LEVEL_ADDR   8'hc3
`define GP_PA_DIR_ADDR     8'hc4
`define GP_PB_DIR_ADDR     8'hc5
`define GP_PC_DIR_ADDR     8'hc6
`define GP_PA_CFG_ADDR     8'hcc
`define GP_PB_CFG_ADDR     8'hce
`define GP_PC_CFG_ADDR     8'hcf

// ==================================================
// Lines that exist, that reach the converter, that drive segments
`define GP_PA_MASK         8'hf0
`define GP_PB_MASK         8'hff
`define GP_PC_MASK         8'hff
`define GP_PA_ANALOG_MASK  8'hf0
`define GP_PB_ANALOG_MASK  8'h0f
`define GP_PC_ANALOG_MASK  8'h00
`define GP_PC_SEG_MASK     8'hff

// ==================================================
// Reset values; port C starts in segment mode
`define GP_DIR_RESET       8'h00
`define GP_AB_CFG_RESET    8'h00
`define GP_AB_LEVEL_RESET  8'h00
`define GP_PC_CFG_RESET    8'hff
`define GP_PC_LEVEL_RESET  8'hff
`define GP_RDATA_RESET     8'h00

// ==================================================
// Serial line positions on port B
`define GP_SPI_PORT        1
`define GP_SPI_SCK_BIT     5
`define GP_SPI_SIN_BIT     6
`define GP_SPI_SOUT_BIT    7

`endif

// ### core/gpio_pkg.sv
// Types and mode decoding shared by the port logic.
// Assumes nothing beyond the cfg header.
package gpio_pkg;

  typedef enum {
    MODE_PULLUP_IN,
    MODE_FLOAT_IN,
    MODE_IRQ_IN,
    MODE_ANALOG_IN,
    MODE_SEGMENT,
    MODE_OPEN_DRAIN,
    MODE_PUSH_PULL
  } line_mode_e;

  typedef enum logic [1:0] {
    TRIG_FALL,
    TRIG_RISE,
    TRIG_LOW
  } trig_e;

  // ==================================================
  // Direction, option and level bit to line mode
  function automatic line_mode_e decode_mode(
    input logic dir,
    input logic cfg,
    input logic lvl,
    input logic analog_ok,
    input logic seg_ok
  );
    line_mode_e m;
    m = MODE_PULLUP_IN;
    if (dir)
      m = cfg ? MODE_PUSH_PULL : MODE_OPEN_DRAIN;
    else
    begin
      case ({cfg, lvl})
        2'h0: m = MODE_PULLUP_IN;
        2'h1: m = MODE_FLOAT_IN;
        2'h2: m = MODE_IRQ_IN;
        2'h3:
        begin
          // Without a segment or converter input the code falls back to a floating input
          if (seg_ok)
            m = MODE_SEGMENT;
          else if (analog_ok)
            m = MODE_ANALOG_IN;
          else
            m = MODE_FLOAT_IN;
        end
        default: m = MODE_PULLUP_IN;
      endcase
    end
    return m;
  endfunction

endpackage

// ### core/gpio_sync.sv
// Two-flop synchroniser for one byte of pin levels.
// Assumes pins are asynchronous to the core clock.
`timescale 1ns/10ps
module gpio_sync (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [7:0] i_async,
  output logic      [7:0] o_sync
);
  logic [7:0] meta_q;
  logic [7:0] sync_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// ### core/gpio_line.sv
// Pad control for one port line, decoded from its three bits.
// Assumes the caller registers the outputs.
`timescale 1ns/10ps
module gpio_line #(
  parameter bit ANALOG_OK = 1'b0,
  parameter bit SEG_OK    = 1'b0
) (
  input  wire logic i_dir,
  input  wire logic i_cfg,
  input  wire logic i_lvl,
  input  wire logic i_od_data,
  input  wire logic i_seg,
  output logic      o_out,
  output logic      o_oe_n,
  output logic      o_pullup,
  output logic      o_irq_en,
  output logic      o_analog,
  output logic      o_seg_en
);
  gpio_pkg::line_mode_e mode;

  always_comb
  begin
    mode     = gpio_pkg::decode_mode(i_dir, i_cfg, i_lvl, ANALOG_OK, SEG_OK); // R2
    o_out    = 1'b0;
    o_oe_n   = 1'b1;
    o_pullup = 1'b0;
    o_irq_en = 1'b0;
    o_analog = 1'b0;
    o_seg_en = 1'b0;
    case (mode)
      gpio_pkg::MODE_PULLUP_IN: o_pullup = 1'b1; // R15
      gpio_pkg::MODE_FLOAT_IN:  o_pullup = 1'b0; // R15
      gpio_pkg::MODE_IRQ_IN:
      begin
        o_pullup = 1'b1; // R15
        o_irq_en = 1'b1; // R17
      end
      gpio_pkg::MODE_ANALOG_IN: o_analog = 1'b1; // R18
      gpio_pkg::MODE_SEGMENT:
      begin
        o_out    = i_seg; // R6
        o_oe_n   = 1'b0;
        o_seg_en = 1'b1;
      end
      gpio_pkg::MODE_OPEN_DRAIN:
      begin
        // Only ever pulls low; a high level is left to the load
        o_oe_n = i_lvl & i_od_data; // R12
      end
      gpio_pkg::MODE_PUSH_PULL:
      begin
        o_out  = i_lvl; // R13
        o_oe_n = 1'b0;
      end
      default: o_oe_n = 1'b1;
    endcase
  end
endmodule

// ### core/gpio_ports.sv
// Three bytewise I/O ports with segment and serial alternates.
// Assumes a core-side data-space strobe interface on I_REF_CLK,
// and that pad logic resolves each pin from out and oe_n.
//
// Overview of operation
// R1 - Reading a level register in input mode returns the live pin.
// R2 - Stored level bit plus option bit still select input behaviour.
// R3 - Software keeps a RAM copy; bit operations rewrite all latches.
// R4 - Software masks bits without physical lines before whole-byte use.
// R5 - Software changes line modes only along the safe paths.
// R6 - Port C codes: pull-up, float, interrupt, segment, open-drain, push-pull.
// R7 - Port C lines leave reset as LCD segment outputs.
// R8 - Port C segment lines carry controller segments 33 to 40 in order.
// R9 - All other lines reset to pull-up input without interrupt.
// R10 - Software sets serial input and clock lines to input before slave use.
// R11 - Serial input and clock lines stay readable in every input mode.
// R12 - Serial output reaches its line only in open-drain mode.
// R13 - A push-pull serial output line shows only its latch.
// R14 - Each port has 8-bit option, direction and level registers, bit n line n.
// R15 - Ordinary codes: pull-up, float, interrupt, analog, open-drain, push-pull.
// R16 - Initialisation clears registers to pull-up input, no interrupt.
// R17 - Interrupt-mode lines feed a per-port trigger of chosen kind.
// R18 - Analog mode routes the pin to the converter, no pull-up or interrupt.
// R19 - Bits without a physical line read zero and ignore writes.
`timescale 1ns/10ps
`include "gpio_cfg.svh"
module gpio_ports (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_NRST,
  input  wire logic [7:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR_EN,
  input  wire logic       I_RD_EN,
  output logic      [7:0] O_RDATA,
  input  wire logic [7:0] I_PA_PIN,
  output logic      [7:0] O_PA_OUT,
  output logic      [7:0] O_PA_OE_N,
  output logic      [7:0] O_PA_PULLUP,
  output logic      [7:0] O_PA_ANALOG,
  input  wire logic [7:0] I_PB_PIN,
  output logic      [7:0] O_PB_OUT,
  output logic      [7:0] O_PB_OE_N,
  output logic      [7:0] O_PB_PULLUP,
  output logic      [7:0] O_PB_ANALOG,
  input  wire logic [7:0] I_PC_PIN,
  output logic      [7:0] O_PC_OUT,
  output logic      [7:0] O_PC_OE_N,
  output logic      [7:0] O_PC_PULLUP,
  output logic      [7:0] O_PC_SEG_EN,
  input  wire logic [7:0] I_LCD_SEG,
  input  wire logic [1:0] I_TRIG_A,
  input  wire logic [1:0] I_TRIG_B,
  input  wire logic [1:0] I_TRIG_C,
  output logic            O_IRQ_A,
  output logic            O_IRQ_B,
  output logic            O_IRQ_C,
  input  wire logic       I_SPI_SOUT,
  output logic            O_SPI_SIN,
  output logic            O_SPI_SCK
);

  // ==================================================
  // Per-port constants
  localparam logic [7:0] PHYS_MASK [0:2] = '{`GP_PA_MASK, `GP_PB_MASK, `GP_PC_MASK};
  localparam logic [7:0] ANA_MASK  [0:2] = '{`GP_PA_ANALOG_MASK, `GP_PB_ANALOG_MASK, `GP_PC_ANALOG_MASK};
  localparam logic [7:0] SEG_MASK  [0:2] = '{8'h00, 8'h00, `GP_PC_SEG_MASK};
  localparam logic [7:0] CFG_RST   [0:2] = '{`GP_AB_CFG_RESET, `GP_AB_CFG_RESET, `GP_PC_CFG_RESET};
  localparam logic [7:0] LVL_RST   [0:2] = '{`GP_AB_LEVEL_RESET, `GP_AB_LEVEL_RESET, `GP_PC_LEVEL_RESET};

  localparam logic [1:0] KIND_LVL  = 2'h0;
  localparam logic [1:0] KIND_DIR  = 2'h1;
  localparam logic [1:0] KIND_CFG  = 2'h2;
  localparam logic [1:0] KIND_NONE = 2'h3;

  // ==================================================
  // Address decode, shared by the write and read paths
  function automatic logic [3:0] reg_sel(input logic [7:0] addr);
    logic [3:0] s;
    s = {KIND_NONE, 2'h0};
    case (addr)
      `GP_PA_LEVEL_ADDR: s = {KIND_LVL, 2'h0};
      `GP_PB_LEVEL_ADDR: s = {KIND_LVL, 2'h1};
      `GP_PC_LEVEL_ADDR: s = {KIND_LVL, 2'h2};
      `GP_PA_DIR_ADDR:   s = {KIND_DIR, 2'h0};
      `GP_PB_DIR_ADDR:   s = {KIND_DIR, 2'h1};
      `GP_PC_DIR_ADDR:   s = {KIND_DIR, 2'h2};
      `GP_PA_CFG_ADDR:   s = {KIND_CFG, 2'h0};
      `GP_PB_CFG_ADDR:   s = {KIND_CFG, 2'h1};
      `GP_PC_CFG_ADDR:   s = {KIND_CFG, 2'h2};
      default:           s = {KIND_NONE, 2'h0};
    endcase
    return s;
  endfunction

  // ==================================================
  // Register state
  logic [7:0] dir_q   [0:2];
  logic [7:0] dir_d   [0:2];
  logic [7:0] cfg_q   [0:2];
  logic [7:0] cfg_d   [0:2];
  logic [7:0] lvl_q   [0:2];
  logic [7:0] lvl_d   [0:2];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] pin_raw [0:2];
  logic [7:0] pin_s   [0:2];
  logic [7:0] pin_view [0:2];
  logic [3:0] wsel;
  logic [3:0] rsel;
  integer     k;

  assign pin_raw[0] = I_PA_PIN;
  assign pin_raw[1] = I_PB_PIN;
  assign pin_raw[2] = I_PC_PIN;
  assign wsel       = reg_sel(I_ADDR);
  assign rsel       = wsel;

  genvar p;
  genvar n;
  generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_sync
      gpio_sync u_sync (
        .i_clk   (I_REF_CLK),
        .i_nrst  (I_NRST),
        .i_async (pin_raw[p]),
        .o_sync  (pin_s[p])
      );
      // Input lines show the pin, outputs show their latch
      assign pin_view[p] = ((dir_q[p] & lvl_q[p]) | (~dir_q[p] & pin_s[p])) & PHYS_MASK[p]; // R1 R11 R19
    end
  endgenerate

  // ==================================================
  // Register writes and read data
  always_comb
  begin
    rdata_d = rdata_q;
    for (k = 0; k < 3; k = k + 1)
    begin
      dir_d[k] = dir_q[k];
      cfg_d[k] = cfg_q[k];
      lvl_d[k] = lvl_q[k];
    end
    if (I_WR_EN)
    begin
      // A write replaces the whole latch byte, whatever the pins read
      case (wsel[3:2])
        KIND_LVL: lvl_d[wsel[1:0]] = I_WDATA & PHYS_MASK[wsel[1:0]]; // R14 R19 R3
        KIND_DIR: dir_d[wsel[1:0]] = I_WDATA & PHYS_MASK[wsel[1:0]]; // R14 R19
        KIND_CFG: cfg_d[wsel[1:0]] = I_WDATA & PHYS_MASK[wsel[1:0]]; // R14 R19
        default:  rdata_d = rdata_q;
      endcase
    end
    if (I_RD_EN)
    begin
      case (rsel[3:2])
        KIND_LVL: rdata_d = pin_view[rsel[1:0]]; // R1
        KIND_DIR: rdata_d = dir_q[rsel[1:0]]; // R14
        KIND_CFG: rdata_d = cfg_q[rsel[1:0]]; // R14
        default:  rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      for (int i = 0; i < 3; i = i + 1)
      begin
        dir_q[i] <= `GP_DIR_RESET; // R16 R9
        cfg_q[i] <= CFG_RST[i]; // R7 R9
        lvl_q[i] <= LVL_RST[i]; // R7 R16
      end
      rdata_q <= `GP_RDATA_RESET;
    end
    else
    begin
      for (int i = 0; i < 3; i = i + 1)
      begin
        dir_q[i] <= dir_d[i];
        cfg_q[i] <= cfg_d[i];
        lvl_q[i] <= lvl_d[i];
      end
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;

  // ==================================================
  // Line decoders
  logic [7:0] out_c    [0:2];
  logic [7:0] oe_n_c   [0:2];
  logic [7:0] pull_c   [0:2];
  logic [7:0] irq_en_c [0:2];
  logic [7:0] ana_c    [0:2];
  logic [7:0] seg_en_c [0:2];

  generate
    for (p = 0; p < 3; p = p + 1)
    begin : g_port
      for (n = 0; n < 8; n = n + 1)
      begin : g_line
        // Only the serial output line sees the shift data
        localparam bit IS_SOUT = (p == `GP_SPI_PORT) && (n == `GP_SPI_SOUT_BIT);
        logic od_data;
        logic o_raw;
        logic oe_raw;
        logic pu_raw;
        logic ir_raw;
        logic an_raw;
        logic sg_raw;
        assign od_data = IS_SOUT ? I_SPI_SOUT : 1'b1; // R12
        gpio_line #(
          .ANALOG_OK (ANA_MASK[p][n]),
          .SEG_OK    (SEG_MASK[p][n])
        ) u_line (
          .i_dir     (dir_q[p][n]),
          .i_cfg     (cfg_q[p][n]),
          .i_lvl     (lvl_q[p][n]),
          .i_od_data (od_data),
          .i_seg     (I_LCD_SEG[n]),
          .o_out     (o_raw),
          .o_oe_n    (oe_raw),
          .o_pullup  (pu_raw),
          .o_irq_en  (ir_raw),
          .o_analog  (an_raw),
          .o_seg_en  (sg_raw)
        );
        // Absent lines never drive and never pull
        assign out_c[p][n]    = o_raw & PHYS_MASK[p][n];
        assign oe_n_c[p][n]   = oe_raw | ~PHYS_MASK[p][n]; // R19
        assign pull_c[p][n]   = pu_raw & PHYS_MASK[p][n];
        assign irq_en_c[p][n] = ir_raw & PHYS_MASK[p][n]; // R17
        assign ana_c[p][n]    = an_raw & PHYS_MASK[p][n]; // R18
        assign seg_en_c[p][n] = sg_raw; // R8
      end
    end
  endgenerate

  // ==================================================
  // Registered pad controls and interrupt requests
  logic [7:0] out_q   [0:2];
  logic [7:0] oe_n_q  [0:2];
  logic [7:0] pull_q  [0:2];
  logic [7:0] ana_q   [0:2];
  logic [7:0] seg_q;
  logic [7:0] prev_q  [0:2];
  logic [7:0] prev_d  [0:2];
  logic [2:0] irq_q;
  logic [2:0] irq_d;
  logic [1:0] trig    [0:2];
  logic [7:0] fall;
  logic [7:0] rise;
  logic [7:0] low;
  integer     j;

  assign trig[0] = I_TRIG_A;
  assign trig[1] = I_TRIG_B;
  assign trig[2] = I_TRIG_C;

  always_comb
  begin
    fall = 8'h00;
    rise = 8'h00;
    low  = 8'h00;
    for (j = 0; j < 3; j = j + 1)
    begin
      prev_d[j] = pin_s[j];
      fall      = irq_en_c[j] & prev_q[j] & ~pin_s[j];
      rise      = irq_en_c[j] & ~prev_q[j] & pin_s[j];
      low       = irq_en_c[j] & ~pin_s[j];
      // Edge kinds give one-cycle pulses, low level holds while low
      case (trig[j])
        gpio_pkg::TRIG_FALL: irq_d[j] = |fall; // R17
        gpio_pkg::TRIG_RISE: irq_d[j] = |rise; // R17
        gpio_pkg::TRIG_LOW:  irq_d[j] = |low; // R17
        default:             irq_d[j] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_NRST)
    begin
      for (int i = 0; i < 3; i = i + 1)
      begin
        out_q[i]  <= 8'h00;
        oe_n_q[i] <= 8'hff;
        pull_q[i] <= 8'h00;
        ana_q[i]  <= 8'h00;
        prev_q[i] <= 8'h00;
      end
      seg_q <= 8'h00;
      irq_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i = i + 1)
      begin
        out_q[i]  <= out_c[i];
        oe_n_q[i] <= oe_n_c[i];
        pull_q[i] <= pull_c[i];
        ana_q[i]  <= ana_c[i];
        prev_q[i] <= prev_d[i];
      end
      seg_q <= seg_en_c[2]; // R8
      irq_q <= irq_d;
    end
  end

  assign O_PA_OUT    = out_q[0];
  assign O_PA_OE_N   = oe_n_q[0];
  assign O_PA_PULLUP = pull_q[0];
  assign O_PA_ANALOG = ana_q[0];
  assign O_PB_OUT    = out_q[1];
  assign O_PB_OE_N   = oe_n_q[1];
  assign O_PB_PULLUP = pull_q[1];
  assign O_PB_ANALOG = ana_q[1];
  assign O_PC_OUT    = out_q[2];
  assign O_PC_OE_N   = oe_n_q[2];
  assign O_PC_PULLUP = pull_q[2];
  assign O_PC_SEG_EN = seg_q;
  assign O_IRQ_A     = irq_q[0];
  assign O_IRQ_B     = irq_q[1];
  assign O_IRQ_C     = irq_q[2];

  // Serial inputs bypass the mode logic so the shifter always sees them
  assign O_SPI_SIN = pin_s[`GP_SPI_PORT][`GP_SPI_SIN_BIT]; // R11
  assign O_SPI_SCK = pin_s[`GP_SPI_PORT][`GP_SPI_SCK_BIT]; // R11

endmodule

// ### test/gpio_pin_model.sv
// Pin model for one port: external driver, pull-up and floating lines.
// Assumes pads resolve from out and oe_n, oe_n active low.
`timescale 1ns/10ps
module gpio_pin_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe_n,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_pin
);
  logic tick_q = 1'b0;

  // A floating line toggles so that a stale level never reads as valid
  always_ff @(posedge i_clk)
    tick_q <= ~tick_q;

  always_comb
    for (int i = 0; i < 8; i++)
      o_pin[i] = !i_oe_n[i] ? i_out[i] : i_ext_en[i] ? i_ext[i] : i_pullup[i] ? 1'b1 : tick_q;
endmodule

// ### test/gpio_ports_chk.sv
// Concurrent checks on pads, serial taps and the port A request.
// Assumes it is bound into gpio_ports and sees only its ports.
`timescale 1ns/10ps
module gpio_ports_chk (
  input wire logic       I_REF_CLK,
  input wire logic       I_NRST,
  input wire logic [7:0] I_PB_PIN,
  input wire logic [7:0] I_LCD_SEG,
  input wire logic [1:0] I_TRIG_A,
  input wire logic [7:0] O_PA_OE_N,
  input wire logic [7:0] O_PA_PULLUP,
  input wire logic [7:0] O_PA_ANALOG,
  input wire logic [7:0] O_PB_OE_N,
  input wire logic [7:0] O_PB_PULLUP,
  input wire logic [7:0] O_PB_ANALOG,
  input wire logic [7:0] O_PC_OUT,
  input wire logic [7:0] O_PC_OE_N,
  input wire logic [7:0] O_PC_SEG_EN,
  input wire logic       O_IRQ_A,
  input wire logic       O_SPI_SIN,
  input wire logic       O_SPI_SCK
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);

  // ==================================================
  // Reset modes
  AST_RST_SEG: assert property ($rose(I_NRST) |-> ##[1:3] (O_PC_SEG_EN == 8'hff && O_PC_OE_N == 8'h00))
    else $error("port C not in segment mode after reset");
  AST_RST_PULL: assert property ($rose(I_NRST) |-> ##[1:3] (O_PB_PULLUP == 8'hff && O_PA_PULLUP == 8'hf0))
    else $error("ports A and B not pull-up inputs after reset");

  // ==================================================
  // Pad relations
  AST_SEG_DRIVE: assert property (O_PC_SEG_EN != 8'h00 |-> ((O_PC_OUT ^ $past(I_LCD_SEG)) & O_PC_SEG_EN) == 8'h00)
    else $error("segment line does not carry its controller segment");
  AST_SEG_OE: assert property ((O_PC_SEG_EN & O_PC_OE_N) == 8'h00)
    else $error("segment line not driven");
  AST_PA_NOLINE: assert property ((O_PA_OE_N[3:0] & ~O_PA_PULLUP[3:0] & ~O_PA_ANALOG[3:0]) == 4'hf)
    else $error("missing port A line is active");
  AST_ANALOG: assert property (((O_PA_ANALOG & O_PA_PULLUP) | (O_PB_ANALOG & (O_PB_PULLUP | ~O_PB_OE_N))) == 8'h00)
    else $error("analog line keeps pull-up or drive");
  AST_SERIAL_TAP: assert property ($changed({O_SPI_SIN, O_SPI_SCK}) |->
    ({O_SPI_SIN, O_SPI_SCK} == $past(I_PB_PIN[6:5], 2) || {O_SPI_SIN, O_SPI_SCK} == $past(I_PB_PIN[6:5], 3)))
    else $error("serial taps do not follow their pins");

  // ==================================================
  // Port A request
  AST_IRQ_NONE: assert property ((I_TRIG_A == 2'h3) [*4] |-> !O_IRQ_A)
    else $error("request raised with trigger off");
  AST_IRQ_PULSE: assert property ((I_TRIG_A == 2'h0 && $past(I_TRIG_A) == 2'h0 && O_IRQ_A) |=> !O_IRQ_A)
    else $error("edge request longer than one cycle");
endmodule

bind gpio_ports gpio_ports_chk u_chk (
  .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_PB_PIN(I_PB_PIN), .I_LCD_SEG(I_LCD_SEG), .I_TRIG_A(I_TRIG_A),
  .O_PA_OE_N(O_PA_OE_N), .O_PA_PULLUP(O_PA_PULLUP), .O_PA_ANALOG(O_PA_ANALOG), .O_PB_OE_N(O_PB_OE_N),
  .O_PB_PULLUP(O_PB_PULLUP), .O_PB_ANALOG(O_PB_ANALOG), .O_PC_OUT(O_PC_OUT), .O_PC_OE_N(O_PC_OE_N),
  .O_PC_SEG_EN(O_PC_SEG_EN), .O_IRQ_A(O_IRQ_A), .O_SPI_SIN(O_SPI_SIN), .O_SPI_SCK(O_SPI_SCK)
);

// ### test/testbench.sv
// Self-checking bench for the three I/O ports.
// Assumes gpio_ports, the cfg header and one pin model per port.
`timescale 1ns/10ps
`include "gpio_cfg.svh"
module testbench;
  localparam logic [7:0] LVL [3] = '{`GP_PA_LEVEL_ADDR, `GP_PB_LEVEL_ADDR, `GP_PC_LEVEL_ADDR};
  localparam logic [7:0] DIR [3] = '{`GP_PA_DIR_ADDR, `GP_PB_DIR_ADDR, `GP_PC_DIR_ADDR};
  localparam logic [7:0] CFG [3] = '{`GP_PA_CFG_ADDR, `GP_PB_CFG_ADDR, `GP_PC_CFG_ADDR};
  localparam logic [7:0] MSK [3] = '{`GP_PA_MASK, `GP_PB_MASK, `GP_PC_MASK};
  localparam logic [7:0] AMK [3] = '{`GP_PA_ANALOG_MASK, `GP_PB_ANALOG_MASK, `GP_PC_SEG_MASK};
  logic       clk, nrst, wr_en, rd_en, sout, irq_a, irq_b, irq_c, sin, sck;
  logic [7:0] addr, wdata, rdata, lcd, d, l, e, n;
  logic [1:0] trig;
  logic [7:0] pin [3], out [3], oe_n [3], pull [3], alt [3], ext [3], ext_en [3];
  logic [7:0] exp_q [$];
  int         num_errors = 0;
  int         check_count = 0;

  gpio_ports DUT (
    .I_REF_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
    .O_RDATA(rdata), .I_PA_PIN(pin[0]), .O_PA_OUT(out[0]), .O_PA_OE_N(oe_n[0]), .O_PA_PULLUP(pull[0]),
    .O_PA_ANALOG(alt[0]), .I_PB_PIN(pin[1]), .O_PB_OUT(out[1]), .O_PB_OE_N(oe_n[1]), .O_PB_PULLUP(pull[1]),
    .O_PB_ANALOG(alt[1]), .I_PC_PIN(pin[2]), .O_PC_OUT(out[2]), .O_PC_OE_N(oe_n[2]), .O_PC_PULLUP(pull[2]),
    .O_PC_SEG_EN(alt[2]), .I_LCD_SEG(lcd), .I_TRIG_A(trig), .I_TRIG_B(trig), .I_TRIG_C(trig),
    .O_IRQ_A(irq_a), .O_IRQ_B(irq_b), .O_IRQ_C(irq_c), .I_SPI_SOUT(sout), .O_SPI_SIN(sin), .O_SPI_SCK(sck)
  );

  for (genvar p = 0; p < 3; p++)
  begin : g_pin
    gpio_pin_model u_pin (.i_clk(clk), .i_out(out[p]), .i_oe_n(oe_n[p]), .i_pullup(pull[p]),
                          .i_ext(ext[p]), .i_ext_en(ext_en[p]), .o_pin(pin[p]));
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==================================================
  // Shared tasks
  task automatic cmp8(input string nm, input logic [7:0] ev, input logic [7:0] gv);
    check_count++;
    if (gv !== ev)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  // Whole-byte access only; a read leaves its expected value in the queue
  task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] dv, input logic [7:0] ev);
    if (!w)
      exp_q.push_back(ev);
    @(posedge clk);
    #2;
    addr = a;
    wdata = dv;
    wr_en = w;
    rd_en = !w;
    @(posedge clk);
    #2;
    wr_en = 1'b0;
    rd_en = 1'b0;
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
    if (rd_en === 1'b1)
    begin
      @(posedge clk);
      #1;
      cmp8("rdata", exp_q.pop_front(), rdata);
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  // ==================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hfa32));
    {nrst, wr_en, rd_en, addr, wdata} = '0;
    {sout, trig, lcd} = {1'b1, 2'h3, 8'($urandom)};
    for (int p = 0; p < 3; p++)
      {ext[p], ext_en[p]} = 16'hffff;
    repeat (8) @(posedge clk);
    #2;
    nrst = 1'b1;
    tick(4);
    cmp8("pc_seg_en", 8'hff, alt[2]);
    cmp8("pb_pullup", 8'hff, pull[1]);
    cmp8("pa_pullup", `GP_PA_MASK, pull[0]);
    lcd = 8'($urandom);
    tick(2);
    cmp8("seg_out", lcd, out[2]);
    acc(0, 8'hc2, 8'h00, 8'h00);
    for (int p = 0; p < 3; p++)
    begin
      acc(0, DIR[p], 8'h00, 8'h00);
      acc(0, CFG[p], 8'h00, p == 2 ? `GP_PC_CFG_RESET : 8'h00);
      for (int r = 0; r < 2; r++)
      begin
        d = 8'($urandom);
        acc(1, r ? CFG[p] : DIR[p], d, 8'h00);
        acc(0, r ? CFG[p] : DIR[p], 8'h00, d & MSK[p]);
      end
    end
    for (int p = 0; p < 3; p++)
    begin
      {d, l, ext[p]} = 24'($urandom);
      acc(1, LVL[p], l, 8'h00);
      acc(1, CFG[p], d, 8'h00);
      acc(1, DIR[p], d, 8'h00);
      tick(3);
      acc(0, LVL[p], 8'h00, ((d & l) | (~d & ext[p])) & MSK[p]);
      cmp8("oe_n", ~(d & MSK[p]), oe_n[p]);
      cmp8("out", d & l & MSK[p], out[p]);
      cmp8("pullup", ~d & ~l & MSK[p], pull[p]);
      for (int c = 0; c < 6; c++)
      begin
        l = 8'($urandom);
        acc(1, LVL[p], c < 4 ? {8{c[0]}} : l, 8'h00);
        acc(1, CFG[p], {8{c < 4 ? c[1] : c[0]}}, 8'h00);
        acc(1, DIR[p], {8{c > 3}}, 8'h00);
        tick(2);
        cmp8("pullup", (c == 0 || c == 2) ? MSK[p] : 8'h00, pull[p]);
        cmp8("alt", c == 3 ? AMK[p] : 8'h00, alt[p]);
        e = c == 5 ? ~MSK[p] : c == 4 ? l | ~MSK[p] : (c == 3 && p == 2) ? 8'h00 : 8'hff;
        cmp8("oe_n", e, oe_n[p]);
        if (c > 3)
          cmp8("out", c == 5 ? l & MSK[p] : 8'h00, out[p]);
      end
    end
    acc(1, CFG[1], 8'h00, 8'h00);
    acc(1, DIR[1], 8'h80, 8'h00);
    acc(1, LVL[1], 8'h80, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      if (k == 2)
        acc(1, CFG[1], 8'h80, 8'h00);
      sout = k[0];
      ext[1] = 8'($urandom);
      tick(4);
      cmp8("sout_oe_n", {7'h0, k < 2 ? k[0] : 1'b0}, {7'h0, oe_n[1][7]});
      cmp8("sout_out", {7'h0, k > 1}, {7'h0, out[1][7]});
      cmp8("serial_in", {6'h0, ext[1][6:5]}, {6'h0, sin, sck});
      acc(0, LVL[1], 8'h00, {1'b1, ext[1][6:0]});
    end
    ext[0] = 8'hff;
    acc(1, DIR[0], 8'h00, 8'h00);
    acc(1, CFG[0], 8'h10, 8'h00);
    acc(1, LVL[0], 8'h00, 8'h00);
    // Falling then rising pin edge under every trigger kind
    for (int t = 0; t < 4; t++)
      for (int f = 0; f < 2; f++)
      begin
        trig = t[1:0];
        ext[0][4] = f[0];
        n = 8'h00;
        repeat (8)
        begin
          @(posedge clk);
          // Look after the edge so the request launched there has settled
          #1;
          n = n + {7'h0, irq_a === 1'b1};
        end
        #1;
        cmp8("irq", {7'h0, t == 2 ? f == 0 : t == f}, t == 2 ? {7'h0, irq_a} : n);
        cmp8("irq_bc", 8'h00, {6'h0, irq_b, irq_c});
      end
    tick(2);
    stop_test();
  end
endmodule
